// *** core/gpio_pkg.sv ***
// constants for the shared-pin general purpose port
package gpio_pkg;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam logic [11:0] DIRECTION_OFFSET = 12'h004;
  localparam logic [11:0] LEVEL_OFFSET = 12'h008;
  localparam int PIN_LOW_BIT = 1;
  localparam int PIN_HIGH_BIT = 3;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [2:0] DIRECTION_RESET = 3'h0;
  localparam int STRAP_WIDTH = 16;
  localparam int STRAP_MODE_LSB = 6;
  localparam int STRAP_MEDIA_BIT = 14;
  localparam logic [1:0] STRAP_MODE_ALL_GENERAL = 2'h0;
  localparam logic [1:0] STRAP_MODE_ALL_DRAM = 2'h3;
  localparam logic [15:0] STRAP_RESET = 16'h0000;
endpackage

// *** core/shared_pin_gpio_port.sv ***
// three general pins sharing package pins with dram address and media power
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module shared_pin_gpio_port
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [gpio_pkg::DATA_WIDTH-1:0] pwdata,
  output logic [gpio_pkg::DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration straps, sampled at reset release
  input wire logic [gpio_pkg::STRAP_WIDTH-1:0] configStrapBits,
  // alternate functions of the shared pins
  input wire logic dramAddrLineNine,
  input wire logic dramAddrLineTen,
  input wire logic dramAddrLineEleven,
  input wire logic mediaPortPowerEnable,
  // shared pins, index is the pin number
  input wire logic [3:1] generalPinIn,
  output logic [3:1] generalPinOut,
  output logic [3:1] generalPinOe_n
);

  // read value of one pin: live level when a general input, else stored bit
  function automatic logic pinReadback(input logic enabled, input logic isOutput,
                                       input logic live, input logic stored);
    pinReadback = (enabled && !isOutput) ? live : stored;
  endfunction

  logic [3:1] pinMeta;
  logic [3:1] pinSync;
  logic [15:0] strapMeta;
  logic [15:0] strapSync;
  logic [15:0] strapLatched;
  logic strapTaken;
  logic [3:1] level;
  logic [3:1] direction;
  logic [3:1] next_level;
  logic [3:1] next_direction;
  logic [15:0] next_strapLatched;
  logic next_strapTaken;
  logic [31:0] next_prdata;
  logic [3:1] next_generalPinOut;
  logic [3:1] next_generalPinOe_n;
  logic [3:1] generalEnable;
  logic [3:1] altValue;
  logic [1:0] strapMode;
  logic hitLevel;
  logic hitDirection;
  logic aligned;
  logic writeDone;

  assign strapMode = strapLatched[gpio_pkg::STRAP_MODE_LSB +: 2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hitLevel = aligned && (paddr == gpio_pkg::LEVEL_OFFSET);
  assign hitDirection = aligned && (paddr == gpio_pkg::DIRECTION_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hitLevel || hitDirection);
  assign writeDone = psel && penable && pwrite;

  // pin function decode from latched straps
  always_comb
  begin
    generalEnable[3] = strapTaken && (strapMode == gpio_pkg::STRAP_MODE_ALL_GENERAL);
    generalEnable[1] = strapTaken && (strapMode != gpio_pkg::STRAP_MODE_ALL_DRAM);
    generalEnable[2] = strapTaken && (strapMode != gpio_pkg::STRAP_MODE_ALL_DRAM)
                       && !strapLatched[gpio_pkg::STRAP_MEDIA_BIT];
    altValue[3] = dramAddrLineNine;
    altValue[1] = dramAddrLineTen;
    if (strapMode == gpio_pkg::STRAP_MODE_ALL_DRAM)
    begin
      altValue[2] = dramAddrLineEleven;
    end
    else
    begin
      altValue[2] = mediaPortPowerEnable;
    end
  end

  // strap capture once after reset release
  always_comb
  begin
    next_strapLatched = strapLatched;
    next_strapTaken = 1'b1;
    if (!strapTaken)
    begin
      next_strapLatched = strapSync;
    end
  end

  // register writes and read data
  always_comb
  begin
    next_level = level;
    next_direction = direction;
    next_prdata = prdata;
    if (writeDone && hitLevel)
    begin
      next_level = pwdata[gpio_pkg::PIN_HIGH_BIT:gpio_pkg::PIN_LOW_BIT];
    end
    if (writeDone && hitDirection)
    begin
      next_direction = pwdata[gpio_pkg::PIN_HIGH_BIT:gpio_pkg::PIN_LOW_BIT];
    end
    if (psel && !penable && !pwrite)
    begin
      next_prdata = 32'h0;
      if (hitLevel)
      begin
        for (int p = 1; p <= 3; p++)
        begin
          next_prdata[p] = pinReadback(generalEnable[p], direction[p], pinSync[p],
                                       level[p]);
        end
      end
      else if (hitDirection)
      begin
        next_prdata[3:1] = direction;
      end
    end
  end

  // pin drivers
  always_comb
  begin
    for (int p = 1; p <= 3; p++)
    begin
      if (generalEnable[p])
      begin
        next_generalPinOut[p] = level[p];
        next_generalPinOe_n[p] = !direction[p];
      end
      else if (strapTaken)
      begin
        next_generalPinOut[p] = altValue[p];
        next_generalPinOe_n[p] = 1'b0;
      end
      else
      begin
        next_generalPinOut[p] = 1'b0;
        next_generalPinOe_n[p] = 1'b1;
      end
    end
  end

  // synchronisers, no reset needed
  always_ff @(posedge clk)
  begin
    pinMeta <= generalPinIn;
    pinSync <= pinMeta;
    strapMeta <= configStrapBits;
    strapSync <= strapMeta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strapLatched <= gpio_pkg::STRAP_RESET;
      strapTaken <= 1'b0;
      level <= gpio_pkg::LEVEL_RESET;
      direction <= gpio_pkg::DIRECTION_RESET;
      prdata <= 32'h0;
      generalPinOut <= 3'h0;
      generalPinOe_n <= 3'h7;
    end
    else
    begin
      strapLatched <= next_strapLatched;
      strapTaken <= next_strapTaken;
      level <= next_level;
      direction <= next_direction;
      prdata <= next_prdata;
      generalPinOut <= next_generalPinOut;
      generalPinOe_n <= next_generalPinOe_n;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  pin3_drive_a: assert property (generalEnable[3] && direction[3] |=>
    generalPinOut[3] == $past(level[3]) && !generalPinOe_n[3]) else $error("pin three drive");
  pin2_drive_a: assert property (generalEnable[2] && direction[2] |=>
    generalPinOut[2] == $past(level[2]) && !generalPinOe_n[2]) else $error("pin two drive");
  pin1_drive_a: assert property (generalEnable[1] && direction[1] |=>
    generalPinOut[1] == $past(level[1]) && !generalPinOe_n[1]) else $error("pin one drive");
  pin3_read_a: assert property (psel && !penable && !pwrite && hitLevel
    && generalEnable[3] && !direction[3] |=> prdata[3] == $past(pinSync[3]))
    else $error("pin three readback");
  pin2_read_a: assert property (psel && !penable && !pwrite && hitLevel
    && generalEnable[2] && !direction[2] |=> prdata[2] == $past(pinSync[2]))
    else $error("pin two readback");
  pin1_read_a: assert property (psel && !penable && !pwrite && hitLevel
    && generalEnable[1] && !direction[1] |=> prdata[1] == $past(pinSync[1]))
    else $error("pin one readback");
  pin3_alt_a: assert property (strapTaken && strapMode != gpio_pkg::STRAP_MODE_ALL_GENERAL
    |=> generalPinOut[3] == $past(dramAddrLineNine) && !generalPinOe_n[3])
    else $error("pin three not dram line");
  pin2_alt_a: assert property (strapTaken && (strapMode == gpio_pkg::STRAP_MODE_ALL_DRAM
    || strapLatched[gpio_pkg::STRAP_MEDIA_BIT]) |=> !generalPinOe_n[2]
    && generalPinOut[2] == (strapMode == gpio_pkg::STRAP_MODE_ALL_DRAM
    ? $past(dramAddrLineEleven) : $past(mediaPortPowerEnable)))
    else $error("pin two not alternate");
  pin1_alt_a: assert property (strapTaken && strapMode == gpio_pkg::STRAP_MODE_ALL_DRAM
    |=> generalPinOut[1] == $past(dramAddrLineTen) && !generalPinOe_n[1])
    else $error("pin one not dram line");
  dir_hold_a: assert property (writeDone && hitLevel |=> $stable(direction))
    else $error("direction moved by level write");
  reserved_zero_a: assert property (psel && penable && hitLevel |->
    prdata[31:4] == 28'h0 && !prdata[0]) else $error("reserved bits not zero");
  strap_hold_a: assert property (strapTaken |=> $stable(strapLatched))
    else $error("straps relatched");

endmodule
`default_nettype wire

// *** sim/board_model.sv ***
// board model: straps and pin levels outside the device
`timescale 1ns/10ps
`default_nettype none
module board_model
(
  // strap and pin choices
  input wire logic [15:0] strapChoice,
  input wire logic [3:1] boardLevel,
  // device pins
  input wire logic [3:1] generalPinOut,
  input wire logic [3:1] generalPinOe_n,
  output logic [15:0] configStrapBits,
  output logic [3:1] generalPinIn
);
  assign configStrapBits = strapChoice;
  // board drives only the pins the device releases
  always_comb
  begin
    for (int i = 1; i <= 3; i++)
    begin
      generalPinIn[i] = generalPinOe_n[i] ? boardLevel[i] : generalPinOut[i];
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the shared-pin port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf, v;
  logic pready, pslverr, se;
  logic [15:0] strap, straps[8];
  logic [15:0] cfg;
  logic [3:0] alt;
  logic [3:1] board, pinIn, pinOut, pinOe_n, gm;
  int nErrors, numChecks;
  shared_pin_gpio_port dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .configStrapBits(cfg), .dramAddrLineNine(alt[0]),
    .dramAddrLineTen(alt[1]), .dramAddrLineEleven(alt[2]),
    .mediaPortPowerEnable(alt[3]), .generalPinIn(pinIn), .generalPinOut(pinOut),
    .generalPinOe_n(pinOe_n));
  board_model board_i (.strapChoice(strap), .boardLevel(board), .generalPinOut(pinOut),
    .generalPinOe_n(pinOe_n), .configStrapBits(cfg), .generalPinIn(pinIn));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [3:1] genMask(input logic [15:0] s);
    return {s[7:6] == 2'h0, !s[14] && s[7:6] != 2'h3, s[7:6] != 2'h3};
  endfunction
  function logic [3:1] expOut(input logic [15:0] s, input logic [3:1] l);
    logic [3:1] g;
    g = genMask(s);
    return {g[3] ? l[3] : alt[0], g[2] ? l[2] : (s[7:6] == 2'h3 ? alt[2] : alt[3]),
      g[1] ? l[1] : alt[1]};
  endfunction
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task giveVerdict;
    if (nErrors == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      nErrors++;
      giveVerdict();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    straps = '{16'h0000, 16'h00c0, 16'h4040, 16'h0080, 16'h4000, 16'h40c0, 16'h4080,
      16'h0040};
    strap = 16'h0;
    alt = 4'h0;
    board = 3'h0;
    lf = 32'h2b;
    for (int c = 0; c < 8; c++)
    begin
      strap <= straps[c];
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      gm = genMask(strap);
      lf = lfsr(lf);
      v = lf;
      alt <= lf[7:4];
      apb(1'b1, 12'h004, 32'h0000000e);
      apb(1'b0, 12'h004, 32'h0);
      chk("direction", rd, 32'h0000000e);
      apb(1'b1, 12'h008, v);
      repeat (2) @(posedge clk);
      chk("pinOut", 32'(pinOut), 32'(expOut(strap, v[3:1])));
      chk("pinOe_n", 32'(pinOe_n), 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("levelOut", rd, v & 32'h0000000e);
      lf = lfsr(lf);
      board <= lf[2:0];
      apb(1'b1, 12'h004, 32'h0);
      repeat (3) @(posedge clk);
      chk("pinOe_nIn", 32'(pinOe_n), 32'(gm));
      apb(1'b0, 12'h008, 32'h0);
      chk("levelIn", rd, 32'({(gm & board) | (~gm & v[3:1]), 1'b0}));
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmappedData", rd, 32'h0);
      chk("unmappedErr", 32'(se), 32'h1);
      apb(1'b0, 12'h00a, 32'h0);
      chk("unalignedData", rd, 32'h0);
      chk("unalignedErr", 32'(se), 32'h1);
    end
    giveVerdict();
  end
endmodule
`default_nettype wire
